// [dmsf_data_memory.sv]
// Contract
// RULE_01: general storage at 40H..FFH in three banks, bank select 0, 2 or 3.
// RULE_02: unimplemented locations below 40H read back as 00H.
// RULE_03: region below 40H is shared by all banks.
// RULE_04: every memory bit can be set or cleared singly, except dedicated bits.
// RULE_05: access to 00H or 02H acts on location held by pointer a or b.
// RULE_06: a window reached through a pointer reads 00H and ignores writes.
// RULE_07: no single move from one indirect window to the other.
// RULE_08: pointers are 8 bits; pointer a reaches bank 0, pointer b all banks.
// RULE_09: working register sits at 05H, takes immediates, carries memory moves.
// RULE_10: ALU does add, subtract, decimal adjust, logic, rotates, inc, dec, skips.
// RULE_11: each ALU operation stores its result and updates flags at 0AH; here RL, RR and MOV leave the flags unchanged.
// RULE_12: software writes to flags leave halt and watchdog flags unchanged.
// RULE_13: bit 0 is carry or no-borrow, also moved by rotate through carry.
// RULE_14: bit 1 is low-nibble carry or no nibble borrow.
// RULE_15: bit 2 set when result is zero.
// RULE_16: bit 3 set when carry into msb differs from carry out.
// RULE_17: halt flag cleared by reset or watchdog clear, set by halt.
// RULE_18: watchdog flag cleared by reset, watchdog clear or halt, set on timeout.
// RULE_19: flags bits 6 and 7 always read zero.
// RULE_20: calls and interrupts do not save flags; software must.
// RULE_21: unmapped bank codes read zero and ignore writes above 40H.
module dmsf_data_memory
   import dmsf_pkg::*;
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic [7:0] i_mem_addr,
   input wire logic i_mem_rd,
   input wire logic i_mem_wr,
   input wire logic [7:0] i_mem_wdata,
   input wire logic i_bit_set,
   input wire logic i_bit_clr,
   input wire logic [2:0] i_bit_sel,
   input wire logic i_alu_go,
   input wire logic [3:0] i_alu_op,
   input wire logic i_alu_imm,
   input wire logic i_alu_to_work,
   input wire logic i_halt_op,
   input wire logic i_watchdog_clear_op,
   input wire logic i_watchdog_timeout,
   output logic [7:0] o_mem_rdata,
   output logic o_skip,
   output logic [7:0] o_working_register,
   output logic [7:0] o_flags_register
);

   typedef struct packed {
      logic [GP_BANKS*GP_BYTES-1:0][7:0] mem;
      logic [7:0] pointer_a;
      logic [7:0] pointer_b;
      logic [7:0] bank_select;
      logic [7:0] working_register;
      logic carry_flag;
      logic half_carry_flag;
      logic zero_flag;
      logic signed_overflow_flag;
      logic halt_entered_flag;
      logic watchdog_expired_flag;
      logic [7:0] rdata;
      logic skip;
   } dmsf_state_t;

   dmsf_state_t q;
   dmsf_state_t next_q;

   ////////////////////////////////////////////////////////////////////////////////
   // address resolution

   function automatic dmsf_ref_t resolve(input logic [7:0] a);
      dmsf_ref_t r;
      r.ok = 1'b1;
      r.loc = a;
      r.bank = 2'd0;
      if (a == ADDR_WIN_A) begin
         r.loc = q.pointer_a; // RULE_05
         r.bank = 2'd0; // RULE_08
         if (q.pointer_a == ADDR_WIN_A || q.pointer_a == ADDR_WIN_B) r.ok = 1'b0; // RULE_06
      end else if (a == ADDR_WIN_B) begin
         r.loc = q.pointer_b; // RULE_05
         if (q.pointer_b == ADDR_WIN_A || q.pointer_b == ADDR_WIN_B) r.ok = 1'b0; // RULE_06
      end
      if (r.loc >= GP_BASE && !(a == ADDR_WIN_A)) begin
         if (q.bank_select == BANK_CODE_0) begin
            r.bank = 2'd0; // RULE_01
         end else if (q.bank_select == BANK_CODE_2) begin
            r.bank = 2'd1;
         end else if (q.bank_select == BANK_CODE_3) begin
            r.bank = 2'd2;
         end else begin
            r.ok = 1'b0; // RULE_21
         end
      end
      return r;
   endfunction

   function automatic int unsigned gp_index(input dmsf_ref_t r);
      return int'(r.bank) * GP_BYTES + int'(r.loc - GP_BASE);
   endfunction

   function automatic logic [7:0] flags_byte();
      logic [7:0] f;
      f = ZERO_BYTE; // RULE_19
      f[FLAG_C] = q.carry_flag;
      f[FLAG_HALF_CARRY] = q.half_carry_flag;
      f[FLAG_Z] = q.zero_flag;
      f[FLAG_SIGNED_OVF] = q.signed_overflow_flag;
      f[FLAG_HALT] = q.halt_entered_flag;
      f[FLAG_WDT] = q.watchdog_expired_flag;
      return f;
   endfunction

   // below 40H one copy serves every bank, so bank select is not consulted
   function automatic logic [7:0] read_ref(input dmsf_ref_t r);
      logic [7:0] d;
      d = ZERO_BYTE;
      if (!r.ok) begin
         d = ZERO_BYTE; // RULE_06
      end else if (r.loc >= GP_BASE) begin
         d = q.mem[gp_index(r)]; // RULE_01
      end else if (r.loc == ADDR_PTR_A) begin
         d = q.pointer_a; // RULE_03
      end else if (r.loc == ADDR_PTR_B) begin
         d = q.pointer_b;
      end else if (r.loc == ADDR_BANK) begin
         d = q.bank_select;
      end else if (r.loc == ADDR_WORK) begin
         d = q.working_register; // RULE_09
      end else if (r.loc == ADDR_FLAGS) begin
         d = flags_byte();
      end else begin
         d = ZERO_BYTE; // RULE_02
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   dmsf_ref_t ref_now;
   logic [7:0] cur;
   logic [7:0] opnd;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] low7;
   logic [7:0] res;
   logic [7:0] daa;
   logic cin;
   logic wr_en;
   logic [7:0] wr_data;
   logic upd_z;
   logic upd_arith;
   logic upd_c;
   logic new_c;
   logic is_sub;

   always_comb begin
      next_q = q;
      ref_now = resolve(i_mem_addr);
      cur = read_ref(ref_now);
      opnd = i_alu_imm ? i_mem_wdata : cur; // RULE_09
      is_sub = (i_alu_op == ALU_SUB) || (i_alu_op == ALU_SBC);
      cin = is_sub ? 1'b1 : 1'b0;
      if (i_alu_op == ALU_ADC || i_alu_op == ALU_SBC) cin = q.carry_flag;
      // subtraction is addition of the inverted operand, so carry means no borrow
      sum = {1'b0, q.working_register} + {1'b0, (is_sub ? ~opnd : opnd)} + {8'h00, cin}; // RULE_10
      nib = {1'b0, q.working_register[3:0]} + {1'b0, (is_sub ? ~opnd[3:0] : opnd[3:0])}
            + {4'h0, cin};
      low7 = {1'b0, q.working_register[6:0]} + {1'b0, (is_sub ? ~opnd[6:0] : opnd[6:0])}
             + {7'h00, cin};
      daa = q.working_register;
      if (q.working_register[3:0] > BCD_MAX || q.half_carry_flag) daa = daa + BCD_LO_FIX;
      if (daa[7:4] > BCD_MAX || q.carry_flag) daa = daa + BCD_HI_FIX;
      res = sum[7:0];
      new_c = q.carry_flag;
      upd_z = 1'b0;
      upd_arith = 1'b0;
      upd_c = 1'b0;
      case (dmsf_alu_op_t'(i_alu_op))
         ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
            upd_arith = 1'b1;
            upd_z = 1'b1;
            new_c = sum[8];
         end
         ALU_DAA: begin
            res = daa;
            upd_c = 1'b1;
            new_c = q.carry_flag || (q.working_register > 8'h99);
         end
         ALU_AND: begin
            res = q.working_register & opnd;
            upd_z = 1'b1;
         end
         ALU_OR: begin
            res = q.working_register | opnd;
            upd_z = 1'b1;
         end
         ALU_XOR: begin
            res = q.working_register ^ opnd;
            upd_z = 1'b1;
         end
         ALU_CPL: begin
            res = ~opnd;
            upd_z = 1'b1;
         end
         ALU_RL: res = {opnd[6:0], opnd[7]};
         ALU_RR: res = {opnd[0], opnd[7:1]};
         ALU_RLC: begin
            res = {opnd[6:0], q.carry_flag};
            upd_c = 1'b1;
            new_c = opnd[7]; // RULE_13
         end
         ALU_RRC: begin
            res = {q.carry_flag, opnd[7:1]};
            upd_c = 1'b1;
            new_c = opnd[0]; // RULE_13
         end
         ALU_INC: begin
            res = opnd + 8'h01;
            upd_z = 1'b1;
         end
         ALU_DEC: begin
            res = opnd - 8'h01;
            upd_z = 1'b1;
         end
         default: res = opnd;
      endcase
      // one address per request: a window-to-window move cannot be expressed
      wr_en = 1'b0; // RULE_07
      wr_data = i_mem_wdata;
      next_q.skip = 1'b0;
      if (i_alu_go) begin
         if (i_alu_to_work) begin
            next_q.working_register = res; // RULE_11
         end else begin
            wr_en = 1'b1;
            wr_data = res;
         end
         next_q.skip = (res == ZERO_BYTE);
      end else if (i_bit_set || i_bit_clr) begin
         wr_en = 1'b1;
         wr_data = cur;
         wr_data[i_bit_sel] = i_bit_set; // RULE_04
      end else if (i_mem_wr) begin
         wr_en = 1'b1;
      end
      if (i_mem_rd) next_q.rdata = cur;
      if (wr_en && ref_now.ok) begin
         if (ref_now.loc >= GP_BASE) begin
            next_q.mem[gp_index(ref_now)] = wr_data; // RULE_01
         end else if (ref_now.loc == ADDR_PTR_A) begin
            next_q.pointer_a = wr_data; // RULE_08
         end else if (ref_now.loc == ADDR_PTR_B) begin
            next_q.pointer_b = wr_data;
         end else if (ref_now.loc == ADDR_BANK) begin
            next_q.bank_select = wr_data;
         end else if (ref_now.loc == ADDR_WORK) begin
            next_q.working_register = wr_data;
         end else if (ref_now.loc == ADDR_FLAGS) begin
            next_q.carry_flag = wr_data[FLAG_C]; // RULE_12
            next_q.half_carry_flag = wr_data[FLAG_HALF_CARRY];
            next_q.zero_flag = wr_data[FLAG_Z];
            next_q.signed_overflow_flag = wr_data[FLAG_SIGNED_OVF];
         end
      end
      // flags are never stacked; the ALU result wins over a store to 0AH
      if (i_alu_go) begin // RULE_20
         if (upd_arith || upd_c) next_q.carry_flag = new_c; // RULE_13
         if (upd_arith) next_q.half_carry_flag = nib[4]; // RULE_14
         if (upd_z) next_q.zero_flag = (res == ZERO_BYTE); // RULE_15
         if (upd_arith) next_q.signed_overflow_flag = low7[7] ^ sum[8]; // RULE_16
      end
      if (i_watchdog_clear_op) begin
         next_q.halt_entered_flag = 1'b0; // RULE_17
         next_q.watchdog_expired_flag = 1'b0; // RULE_18
      end
      if (i_halt_op) begin
         next_q.halt_entered_flag = 1'b1; // RULE_17
         next_q.watchdog_expired_flag = 1'b0; // RULE_18
      end
      // a timeout in the same cycle as a clear is kept
      if (i_watchdog_timeout) next_q.watchdog_expired_flag = 1'b1; // RULE_18
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         q <= '0; // RULE_17
      end else begin
         q <= next_q;
      end
   end

   assign o_mem_rdata = q.rdata;
   assign o_skip = q.skip;
   assign o_working_register = q.working_register;
   // a continuous assignment would not see q read inside the function, so it never updates
   always_comb begin
      o_flags_register = flags_byte();
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   logic plain_cycle;
   assign plain_cycle = !i_alu_go && !i_bit_set && !i_bit_clr;

   a_low_reads_zero: assert property ( // RULE_02
      i_mem_rd && i_mem_addr inside {[8'h06:8'h09], [8'h0B:8'h3F]} |=> o_mem_rdata == 8'h00)
      else $error("unimplemented low location did not read zero");

   a_high_bits_zero: assert property (o_flags_register[7:6] == 2'b00) // RULE_19
      else $error("flags bits 7:6 not zero");

   a_flags_wr_keep: assert property ( // RULE_12
      plain_cycle && i_mem_wr && i_mem_addr == ADDR_FLAGS && !i_halt_op
      && !i_watchdog_clear_op && !i_watchdog_timeout
      |=> $stable(o_flags_register[5:4]))
      else $error("flags write changed halt or watchdog flag");

   a_halt_sets: assert property ( // RULE_17
      i_halt_op |=> o_flags_register[FLAG_HALT])
      else $error("halt did not set halt flag");

   a_timeout_sets: assert property ( // RULE_18
      i_watchdog_timeout |=> o_flags_register[FLAG_WDT])
      else $error("timeout lost against a clear");

   a_add_carry: assert property ( // RULE_13
      i_alu_go && i_alu_imm && i_alu_op == ALU_ADD
      |=> o_flags_register[FLAG_C]
          == (({1'b0, $past(o_working_register)} + {1'b0, $past(i_mem_wdata)}) > 9'h0FF))
      else $error("add carry wrong");

   a_zero_follows: assert property ( // RULE_15
      i_alu_go && i_alu_to_work && i_alu_op == ALU_XOR
      |=> o_flags_register[FLAG_Z] == (o_working_register == 8'h00))
      else $error("zero flag does not match result");

   a_bank_store: assert property ( // RULE_01
      (plain_cycle && i_mem_wr && i_mem_addr == 8'h50)
      ##1 (plain_cycle && !i_mem_wr && i_mem_rd && i_mem_addr == 8'h50)
      |=> o_mem_rdata == $past(i_mem_wdata, 2))
      else $error("general storage did not hold written byte");

   a_window_self: assert property ( // RULE_06
      i_mem_rd && i_mem_addr == ADDR_WIN_A && q.pointer_a == ADDR_WIN_B |=> o_mem_rdata == 8'h00)
      else $error("window through pointer did not read zero");

   a_work_mapped: assert property ( // RULE_09
      i_mem_rd && i_mem_addr == ADDR_WORK |=> o_mem_rdata == $past(o_working_register))
      else $error("working register not visible at its location");

   c_add_carry: cover property (i_alu_go && i_alu_op == ALU_ADD ##1 o_flags_register[FLAG_C]);
   c_halt: cover property (i_halt_op ##1 o_flags_register[FLAG_HALT]);
   c_indirect: cover property (i_mem_rd && i_mem_addr == ADDR_WIN_B && q.bank_select == 8'h03);
   c_skip: cover property (i_alu_go && i_alu_op == ALU_DEC ##1 o_skip);

endmodule // dmsf_data_memory

// [dmsf_pkg.sv]
package dmsf_pkg;
   // special function locations
   localparam logic [7:0] ADDR_WIN_A = 8'h00;
   localparam logic [7:0] ADDR_PTR_A = 8'h01;
   localparam logic [7:0] ADDR_WIN_B = 8'h02;
   localparam logic [7:0] ADDR_PTR_B = 8'h03;
   localparam logic [7:0] ADDR_BANK = 8'h04;
   localparam logic [7:0] ADDR_WORK = 8'h05;
   localparam logic [7:0] ADDR_FLAGS = 8'h0A;
   // general-purpose region
   localparam logic [7:0] GP_BASE = 8'h40;
   localparam logic [7:0] GP_LAST = 8'hFF;
   localparam int GP_BYTES = 192;
   localparam int GP_BANKS = 3;
   // bank select codes that map storage
   localparam logic [7:0] BANK_CODE_0 = 8'h00;
   localparam logic [7:0] BANK_CODE_2 = 8'h02;
   localparam logic [7:0] BANK_CODE_3 = 8'h03;
   // flags register bit positions
   localparam int FLAG_C = 0;
   localparam int FLAG_HALF_CARRY = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_SIGNED_OVF = 3;
   localparam int FLAG_HALT = 4;
   localparam int FLAG_WDT = 5;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // decimal adjust constants
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [7:0] BCD_LO_FIX = 8'h06;
   localparam logic [7:0] BCD_HI_FIX = 8'h60;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0,
      ALU_ADC = 4'h1,
      ALU_SUB = 4'h2,
      ALU_SBC = 4'h3,
      ALU_DAA = 4'h4,
      ALU_AND = 4'h5,
      ALU_OR = 4'h6,
      ALU_XOR = 4'h7,
      ALU_CPL = 4'h8,
      ALU_RL = 4'h9,
      ALU_RR = 4'hA,
      ALU_RLC = 4'hB,
      ALU_RRC = 4'hC,
      ALU_INC = 4'hD,
      ALU_DEC = 4'hE,
      ALU_MOV = 4'hF
   } dmsf_alu_op_t;

   typedef struct packed {
      logic ok;
      logic [7:0] loc;
      logic [1:0] bank;
   } dmsf_ref_t;
endpackage : dmsf_pkg

// [tb_top.sv]
module tb_top
   import dmsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] addr; logic rd; logic wr; logic [7:0] wd;
      logic bs; logic bc; logic [2:0] sel; logic go; logic [3:0] op;
      logic imm; logic tow; logic halt; logic wclr; logic wto;
   } dmsf_stim_t;
   typedef struct packed {
      logic [7:0] w; logic [7:0] fin; dmsf_alu_op_t op;
      logic [7:0] opd; logic [7:0] res; logic [7:0] fout;
   } dmsf_row_t;

   logic i_ref_clk;
   logic i_srst;
   dmsf_stim_t s;
   logic [7:0] o_mem_rdata;
   logic o_skip;
   logic [7:0] o_working_register;
   logic [7:0] o_flags_register;
   int miscompares = 0;
   int samples_checked = 0;
   logic [7:0] codes [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
   // each row: working value, flags before, op, immediate, result, flags after
   dmsf_row_t rows [17] = '{
      '{8'h7F, 8'h00, ALU_ADD, 8'h01, 8'h80, 8'h0A}, '{8'hFF, 8'h00, ALU_ADD, 8'h01, 8'h00, 8'h07},
      '{8'h10, 8'h01, ALU_ADC, 8'h20, 8'h31, 8'h00}, '{8'h05, 8'h00, ALU_SUB, 8'h05, 8'h00, 8'h07},
      '{8'h00, 8'h0C, ALU_SBC, 8'h01, 8'hFE, 8'h00}, '{8'h9A, 8'h00, ALU_DAA, 8'h9A, 8'h00, 8'h01},
      '{8'hF0, 8'h0B, ALU_AND, 8'h0F, 8'h00, 8'h0F}, '{8'h50, 8'h04, ALU_OR, 8'h0A, 8'h5A, 8'h00},
      '{8'hFF, 8'h00, ALU_XOR, 8'hFF, 8'h00, 8'h04}, '{8'h3C, 8'h04, ALU_CPL, 8'h3C, 8'hC3, 8'h00},
      '{8'h81, 8'h05, ALU_RL, 8'h81, 8'h03, 8'h05}, '{8'h81, 8'h0A, ALU_RR, 8'h81, 8'hC0, 8'h0A},
      '{8'h80, 8'h00, ALU_RLC, 8'h80, 8'h00, 8'h01}, '{8'h01, 8'h09, ALU_RRC, 8'h01, 8'h80, 8'h09},
      '{8'hFF, 8'h01, ALU_INC, 8'hFF, 8'h00, 8'h05}, '{8'h01, 8'h00, ALU_DEC, 8'h01, 8'h00, 8'h04},
      '{8'h00, 8'h0F, ALU_MOV, 8'h5A, 8'h5A, 8'h0F}};

   dmsf_data_memory dmsf_data_memory_i (
      .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mem_addr(s.addr), .i_mem_rd(s.rd),
      .i_mem_wr(s.wr), .i_mem_wdata(s.wd), .i_bit_set(s.bs), .i_bit_clr(s.bc),
      .i_bit_sel(s.sel), .i_alu_go(s.go), .i_alu_op(s.op), .i_alu_imm(s.imm),
      .i_alu_to_work(s.tow), .i_halt_op(s.halt), .i_watchdog_clear_op(s.wclr),
      .i_watchdog_timeout(s.wto), .o_mem_rdata(o_mem_rdata), .o_skip(o_skip),
      .o_working_register(o_working_register), .o_flags_register(o_flags_register));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one stimulus per call, held for exactly one rising edge, then settled
   task automatic drive(input dmsf_stim_t t);
      @(negedge i_ref_clk);
      s = t;
      @(posedge i_ref_clk);
      #5;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      dmsf_stim_t t;
      t = '0; t.addr = a; t.wr = 1'b1; t.wd = d;
      drive(t);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      dmsf_stim_t t;
      t = '0; t.addr = a; t.rd = 1'b1;
      drive(t);
      chk(o_mem_rdata, e);
   endtask

   task automatic alu(input logic [3:0] op, input logic imm, input logic tow,
                      input logic [7:0] a, input logic [7:0] d);
      dmsf_stim_t t;
      t = '0; t.go = 1'b1; t.op = op; t.imm = imm; t.tow = tow; t.addr = a; t.wd = d;
      drive(t);
   endtask

   task automatic ev(input logic h, input logic c, input logic o);
      dmsf_stim_t t;
      t = '0; t.halt = h; t.wclr = c; t.wto = o;
      drive(t);
   endtask

   task automatic bitop(input logic [7:0] a, input logic st, input logic cl,
                        input logic [2:0] b);
      dmsf_stim_t t;
      t = '0; t.addr = a; t.bs = st; t.bc = cl; t.sel = b;
      drive(t);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end

   // about 120 cycles of work; far beyond that means a hang
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      s = '0;
      i_srst = 1'b1;
      repeat (5) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_srst = 1'b0;
      chk(o_flags_register, 8'h00);
      chk(o_working_register, 8'h00);
      foreach (rows[i]) begin
         wr(ADDR_WORK, rows[i].w);
         wr(ADDR_FLAGS, rows[i].fin);
         alu(rows[i].op, 1'b1, 1'b1, 8'h00, rows[i].opd);
         chk(o_working_register, rows[i].res);
         chk(o_flags_register, rows[i].fout);
         chk({7'h00, o_skip}, {7'h00, rows[i].res == 8'h00});
      end
      // unmapped bank code written last so it cannot hide a shared store
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_BANK, codes[i]);
         wr(GP_BASE, 8'hA0 + 8'(i));
         wr(GP_LAST, 8'hB0 + 8'(i));
      end
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_BANK, codes[i]);
         rd(GP_BASE, (i == 3) ? 8'h00 : 8'hA0 + 8'(i));
         rd(GP_LAST, (i == 3) ? 8'h00 : 8'hB0 + 8'(i));
      end
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h00);
      wr(ADDR_BANK, 8'h00);
      wr(ADDR_PTR_A, 8'h60);
      wr(8'h50, 8'h3C);
      rd(8'h50, 8'h3C);
      wr(ADDR_BANK, 8'h03);
      rd(ADDR_PTR_A, 8'h60);
      wr(ADDR_WIN_A, 8'h11);
      wr(ADDR_PTR_B, 8'h60);
      wr(ADDR_WIN_B, 8'h22);
      rd(ADDR_WIN_A, 8'h11);
      rd(ADDR_WIN_B, 8'h22);
      rd(8'h60, 8'h22);
      wr(ADDR_BANK, 8'h00);
      rd(8'h60, 8'h11);
      wr(ADDR_BANK, 8'h03);
      wr(ADDR_PTR_A, ADDR_WIN_B);
      rd(ADDR_WIN_A, 8'h00);
      wr(ADDR_WIN_A, 8'h77);
      rd(8'h60, 8'h22);
      bitop(8'h60, 1'b1, 1'b0, 3'h7);
      rd(8'h60, 8'hA2);
      bitop(8'h60, 1'b0, 1'b1, 3'h1);
      rd(8'h60, 8'hA0);
      bitop(8'h60, 1'b1, 1'b1, 3'h0);
      rd(8'h60, 8'hA1);
      alu(ALU_INC, 1'b0, 1'b0, 8'h60, 8'h00);
      rd(8'h60, 8'hA2);
      alu(ALU_MOV, 1'b0, 1'b1, 8'h60, 8'h00);
      chk(o_working_register, 8'hA2);
      wr(ADDR_FLAGS, 8'h00);
      ev(1'b1, 1'b0, 1'b0);
      chk(o_flags_register, 8'h10);
      ev(1'b0, 1'b0, 1'b1);
      chk(o_flags_register, 8'h30);
      wr(ADDR_FLAGS, 8'hFF);
      rd(ADDR_FLAGS, 8'h3F);
      ev(1'b1, 1'b0, 1'b0);
      chk(o_flags_register, 8'h1F);
      ev(1'b0, 1'b1, 1'b0);
      chk(o_flags_register, 8'h0F);
      drive('0);
      chk(o_flags_register, 8'h0F);
      ev(1'b1, 1'b0, 1'b0);
      // second reset in mid-run clears flags and storage alike
      @(negedge i_ref_clk);
      s = '0;
      i_srst = 1'b1;
      @(posedge i_ref_clk);
      #5;
      chk(o_flags_register, 8'h00);
      chk(o_working_register, 8'h00);
      @(negedge i_ref_clk);
      i_srst = 1'b0;
      rd(8'h60, 8'h00);
      report_and_stop();
   end
endmodule // tb_top
